// ---- clkdiv_map.svh ----
// register offsets, field positions and reset values of the sample clock divider
// assumes inclusion by bare name from the serial port, the main module and the bench
`ifndef CLKDIV_MAP_SVH
`define CLKDIV_MAP_SVH

`define ADDR_RATIO 15'h0108
`define ADDR_PHASE 15'h0109
`define ADDR_ALIGN 15'h010a

`define RST_RATIO 3'h1
`define RST_PHASE 4'h0
`define RST_AUTO 1'h0
`define RST_SKEW 2'h0

`define RATIO_DIV1 3'h0
`define RATIO_DIV2 3'h1
`define RATIO_DIV4 3'h3
`define RATIO_DIV8 3'h7

`define AUTO_BIT 7
`define NEG_HI 3
`define NEG_LO 2
`define POS_HI 1
`define POS_LO 0

`define SPI_INSTR_BITS 5'h10
`define SPI_LAST_BIT 5'h17
`define SPI_READ_BIT 15

`endif

// ---- clkdiv_pkg.sv ----
// types shared by the divider and its serial register port
// assumes clkdiv_map.svh on the include path
package clkdiv_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_INSTR = 2'b01,
        PH_DATA = 2'b10,
        PH_DONE = 2'b11
    } spi_phase_t;
endpackage

// ---- reg_port_if.sv ----
// register access between the serial port and the divider register file
// assumes one clock domain; wr is a one-cycle pulse
interface reg_port_if;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] rdata;
    modport port (output addr, output wdata, output wr, input rdata);
    modport regs (input addr, input wdata, input wr, output rdata);
endinterface

// ---- spi_reg_port.sv ----
// serial register port: 16-bit instruction (read flag, 15-bit address), 8 data bits, msb first
// assumes sclk, csb and sdi synchronous to clk and far slower than it
module spi_reg_port
    import clkdiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdi,
    output logic sdo,
    output logic sdoEn,
    reg_port_if.port rp
);
    `include "clkdiv_map.svh"

    spi_phase_t phase, next_phase;
    logic [4:0] bitCnt, next_bitCnt;
    logic [15:0] instr, next_instr;
    logic [7:0] dataSh, next_dataSh;
    logic [7:0] outSh, next_outSh;
    logic sclkQ, next_sclkQ;
    logic next_sdo, next_sdoEn, next_wr;
    logic sclkRise, sclkFall, isRead;

    assign sclkRise = sclk & ~sclkQ;
    assign sclkFall = ~sclk & sclkQ;
    assign isRead = instr[`SPI_READ_BIT];
    assign rp.addr = instr[14:0];
    assign rp.wdata = dataSh;

    always_comb begin
        next_phase = phase;
        next_bitCnt = bitCnt;
        next_instr = instr;
        next_dataSh = dataSh;
        next_outSh = outSh;
        next_sclkQ = sclk;
        next_sdo = sdo;
        next_sdoEn = sdoEn;
        next_wr = 1'b0;
        if (csb) begin
            next_phase = PH_IDLE;
            next_bitCnt = 5'h00;
            next_sdoEn = 1'b0;
        end else begin
            case (phase)
                PH_IDLE: begin
                    next_phase = PH_INSTR;
                end
                PH_INSTR: begin
                    if (sclkRise) begin
                        next_instr = {instr[14:0], sdi};
                        next_bitCnt = bitCnt + 5'h01;
                        if (bitCnt == `SPI_INSTR_BITS - 5'h01) begin
                            next_phase = PH_DATA;
                        end
                    end
                end
                PH_DATA: begin
                    // read data leaves on falling edges, first bit taken from the register file
                    if (sclkFall && isRead) begin
                        next_sdoEn = 1'b1;
                        if (bitCnt == `SPI_INSTR_BITS) begin
                            next_sdo = rp.rdata[7];
                            next_outSh = {rp.rdata[6:0], 1'b0};
                        end else begin
                            next_sdo = outSh[7];
                            next_outSh = {outSh[6:0], 1'b0};
                        end
                    end
                    if (sclkRise) begin
                        next_dataSh = {dataSh[6:0], sdi};
                        next_bitCnt = bitCnt + 5'h01;
                        if (bitCnt == `SPI_LAST_BIT) begin
                            next_phase = PH_DONE;
                            next_wr = ~isRead;
                        end
                    end
                end
                PH_DONE: begin
                    next_phase = PH_DONE;
                end
                default: begin
                    next_phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_IDLE;
            bitCnt <= 5'h00;
            instr <= 16'h0000;
            dataSh <= 8'h00;
            outSh <= 8'h00;
            sclkQ <= 1'b0;
            sdo <= 1'b0;
            sdoEn <= 1'b0;
            rp.wr <= 1'b0;
        end else begin
            phase <= next_phase;
            bitCnt <= next_bitCnt;
            instr <= next_instr;
            dataSh <= next_dataSh;
            outSh <= next_outSh;
            sclkQ <= next_sclkQ;
            sdo <= next_sdo;
            sdoEn <= next_sdoEn;
            rp.wr <= next_wr;
        end
    end
endmodule

// ---- sample_clock_divider_phase.sv ----
// sample clock divider with programmable ratio, half-cycle phase offset and timing-reference realignment
// assumes clk is the input sample clock; sysref and serial pins are synchronous to it
// Summary of operation
// RQ1: divider select picks 1, 2, 4, 8
// RQ2: phase offset delays in half-cycle steps
// RQ3: code 0001 inverts clock, half cycle
// RQ4: code 1100 gives six cycles delay
// RQ5: autophase off keeps phase on reference
// RQ6: autophase on realigns divider to reference
// RQ7: negative window 00 tolerates no skew
// RQ8: negative codes allow early half-step skew
// RQ9: positive window same encoding, late arrival
// RQ10: reference inside window leaves phase unchanged
// RQ11: reserved bits read zero, ignore writes
module sample_clock_divider_phase
    import clkdiv_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdi,
    output logic sdo,
    output logic sdoEn,
    input wire logic sysref,
    output logic divClk,
    output logic divTick,
    output logic clkInvert,
    output logic realigned
);
    `include "clkdiv_map.svh"

    reg_port_if rp ();

    spi_reg_port spi_reg_port_i (
        .clk(clk),
        .arst_n(arst_n),
        .sclk(sclk),
        .csb(csb),
        .sdi(sdi),
        .sdo(sdo),
        .sdoEn(sdoEn),
        .rp(rp)
    );

    logic [2:0] ratioSel, next_ratioSel;
    logic [3:0] phaseOffset, next_phaseOffset;
    logic autoPhase, next_autoPhase;
    logic [1:0] negSkew, next_negSkew;
    logic [1:0] posSkew, next_posSkew;
    logic wrRatio;
    logic wrPhase;
    logic wrAlign;
    logic ratioCodeOk;

    // one write strobe per register; unmapped addresses raise none
    always_comb begin
        wrRatio = 1'b0;
        wrPhase = 1'b0;
        wrAlign = 1'b0;
        case (rp.addr)
            `ADDR_RATIO: begin
                wrRatio = rp.wr;
            end
            `ADDR_PHASE: begin
                wrPhase = rp.wr;
            end
            `ADDR_ALIGN: begin
                wrAlign = rp.wr;
            end
            default: begin
            end
        endcase
    end

    // RQ1: only listed codes taken
    // other codes would leave gaps in the wrap mask, so they keep the old ratio
    always_comb begin
        case (rp.wdata[2:0])
            `RATIO_DIV1: ratioCodeOk = 1'b1;
            `RATIO_DIV2: ratioCodeOk = 1'b1;
            `RATIO_DIV4: ratioCodeOk = 1'b1;
            `RATIO_DIV8: ratioCodeOk = 1'b1;
            default: ratioCodeOk = 1'b0;
        endcase
    end

    // register file; reserved bits have no storage
    always_comb begin
        next_ratioSel = ratioSel;
        next_phaseOffset = phaseOffset;
        next_autoPhase = autoPhase;
        next_negSkew = negSkew;
        next_posSkew = posSkew;
        if (wrRatio && ratioCodeOk) begin
            next_ratioSel = rp.wdata[2:0];
        end
        if (wrPhase) begin
            next_phaseOffset = rp.wdata[3:0];
        end
        if (wrAlign) begin
            next_autoPhase = rp.wdata[`AUTO_BIT];
            next_negSkew = rp.wdata[`NEG_HI:`NEG_LO];
            next_posSkew = rp.wdata[`POS_HI:`POS_LO];
        end
    end

    // RQ11: reserved bits zero
    // the address stays in the port until the frame ends, so it also selects the read data
    always_comb begin
        case (rp.addr)
            `ADDR_RATIO: begin
                rp.rdata = {5'h00, ratioSel};
            end
            `ADDR_PHASE: begin
                rp.rdata = {4'h0, phaseOffset};
            end
            `ADDR_ALIGN: begin
                rp.rdata = {autoPhase, 3'h0, negSkew, posSkew};
            end
            default: begin
                rp.rdata = 8'h00;
            end
        endcase
    end

    // RQ1: ratio resets to divide by two
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ratioSel <= `RST_RATIO;
            phaseOffset <= `RST_PHASE;
            autoPhase <= `RST_AUTO;
            negSkew <= `RST_SKEW;
            posSkew <= `RST_SKEW;
        end else begin
            ratioSel <= next_ratioSel;
            phaseOffset <= next_phaseOffset;
            autoPhase <= next_autoPhase;
            negSkew <= next_negSkew;
            posSkew <= next_posSkew;
        end
    end

    // divider
    logic [2:0] cnt, next_cnt;
    logic [2:0] mask, shifted;
    logic sysrefQ, sysrefEdge;
    logic [7:0] alignedAt;
    logic inWindow;
    logic next_realigned;
    logic next_divClk, next_divTick, next_clkInvert;

    // RQ1: ratio code is also the counter wrap mask
    assign mask = ratioSel;
    // rising edge only; sysrefQ resets to the idle level so no false edge follows reset
    assign sysrefEdge = sysref & ~sysrefQ;

    // window test per counter phase, in half input clocks from phase zero
    // codes count half input clocks while the counter steps whole ones, so code 01 only passes phase zero
    for (genvar e = 0; e < 8; e++) begin : g_phase
        logic [3:0] lateHalves, earlyHalves;
        // RQ7: offset of the reference from phase zero
        assign lateHalves = {3'(e), 1'b0};
        assign earlyHalves = {(mask - 3'(e) + 3'h1) & mask, 1'b0};
        // RQ8: early arrival within the negative window
        // RQ9: late arrival within the positive window
        assign alignedAt[e] = (e == 0) ||
                              (lateHalves <= {2'h0, posSkew}) ||
                              (earlyHalves <= {2'h0, negSkew});
    end
    // RQ10: inside either window counts as aligned
    assign inWindow = alignedAt[cnt];

    // counter group: free running phase, moved only by a reference outside the window
    always_comb begin
        next_cnt = (cnt + 3'h1) & mask;
        next_realigned = 1'b0;
        // RQ5: reference ignored when autophase off
        // RQ6: realign so the reference cycle is phase zero
        if (autoPhase && sysrefEdge && !inWindow) begin
            // loading 1 makes the reference cycle itself phase zero
            next_cnt = 3'h1 & mask;
            next_realigned = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 3'h0;
            sysrefQ <= 1'b0;
            realigned <= 1'b0;
        end else begin
            cnt <= next_cnt;
            sysrefQ <= sysref;
            realigned <= next_realigned;
        end
    end

    // output group: decoded from the next count so the outputs stay one flop from the counter
    always_comb begin
        // RQ2: whole-cycle part of the offset
        // RQ4: code 1100 lands six cycles late
        shifted = (next_cnt - phaseOffset[3:1]) & mask;
        next_divTick = (shifted == 3'h0);
        // divide by one keeps the level high; otherwise high for the first half of the count
        next_divClk = (mask == 3'h0) ? 1'b1 : ((shifted & (mask ^ (mask >> 1))) == 3'h0);
        // RQ3: odd code selects inverted input clock
        next_clkInvert = phaseOffset[0];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divClk <= 1'b0;
            divTick <= 1'b0;
            clkInvert <= 1'b0;
        end else begin
            divClk <= next_divClk;
            divTick <= next_divTick;
            clkInvert <= next_clkInvert;
        end
    end
endmodule

// ---- clkdiv_props.sv ----
// port checks for the sample clock divider
// assumes binding into sample_clock_divider_phase
module clkdiv_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic csb,
    input wire logic sdo,
    input wire logic sdoEn,
    input wire logic sysref,
    input wire logic divClk,
    input wire logic divTick,
    input wire logic clkInvert,
    input wire logic realigned
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] gap;
    logic [4:0] next_gap;
    always_comb next_gap = divTick ? 5'h0 : gap + 5'h1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) gap <= 5'h0;
        else gap <= next_gap;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    realign_pulse_a: assert property (realigned |=> !realigned)
        else $error("realign pulse too long");
    realign_cause_a: assert property (realigned |-> $past(sysref) || $past(sysref, 2) || $past(sysref, 3))
        else $error("realign without reference");
    tick_gap_a: assert property (gap < 5'h18)
        else $error("divider tick missing");
    tick_high_a: assert property (divTick |-> divClk)
        else $error("tick outside high phase");
    invert_cause_a: assert property ($changed(clkInvert) |-> !$past(csb, 2))
        else $error("invert changed without access");
    read_idle_a: assert property (csb [*3] |-> !sdoEn)
        else $error("read data driven while idle");
    read_start_a: assert property ($rose(sdoEn) |-> !csb && !$past(csb))
        else $error("read data without select");
    read_hold_a: assert property (sdoEn && $past(sdoEn) && $stable(sclk) && sclk == $past(sclk, 2) |-> $stable(sdo))
        else $error("read data moved");
endmodule
bind sample_clock_divider_phase clkdiv_chk clkdiv_chk_i (.clk, .arst_n, .sclk, .csb, .sdo, .sdoEn, .sysref, .divClk,
    .divTick, .clkInvert, .realigned);

// ---- ref_source.sv ----
// timing reference source facing the divider
// assumes fire is a one-cycle request on clk
module ref_source (
    input wire logic clk,
    input wire logic fire,
    output logic sysref
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold = 3'h0;
    always @(posedge clk) begin
        hold <= fire ? 3'h4 : hold - 3'(hold != 3'h0);
    end
    assign sysref = hold != 3'h0;
endmodule

// ---- sample_clock_divider_phase_tb.sv ----
// self-checking bench for the sample clock divider
// assumes the design files and clkdiv_map.svh are compiled first
`include "clkdiv_map.svh"
module sample_clock_divider_phase_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, sclk = 1'b0, csb = 1'b1, sdi = 1'b0, fire = 1'b0;
    logic sdo, sdoEn, sysref, divClk, divTick, clkInvert, realigned, seenEn;
    int fails = 0, checked = 0, cyc = 0, hits = 0;
    sample_clock_divider_phase sample_clock_divider_phase_i (.clk, .arst_n, .sclk, .csb, .sdi, .sdo, .sdoEn,
        .sysref, .divClk, .divTick, .clkInvert, .realigned);
    ref_source ref_source_i (.clk, .fire, .sysref);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (realigned === 1'b1) hits <= hits + 1;
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(logic rd, logic [14:0] a, logic [7:0] d, output logic [7:0] q);
        logic [23:0] w;
        w = {rd, a, d};
        csb <= 1'b0;
        tick(1);
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b0;
            sdi <= w[i];
            tick(3);
            if (i < 8) q[i] = sdo;
            if (i == 0) seenEn = sdoEn;
            sclk <= 1'b1;
            tick(3);
        end
        tick(3);
        csb <= 1'b1;
        sclk <= 1'b0;
        tick(4);
    endtask
    task automatic wr(logic [14:0] a, logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
    endtask
    task automatic rdchk(string what, logic [14:0] a, logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        check(what, exp, q);
        check("drive", 8'h01, {7'h0, seenEn});
        check("release", 8'h00, {7'h0, sdoEn});
    endtask
    task automatic tpos(output int p);
        tick(1);
        for (int i = 0; i < 20 && divTick !== 1'b1; i++) tick(1);
        p = cyc % 8;
    endtask
    task automatic t_reset();
        rdchk("ratio", `ADDR_RATIO, {5'h0, `RST_RATIO});
        rdchk("phase", `ADDR_PHASE, {4'h0, `RST_PHASE});
        rdchk("align", `ADDR_ALIGN, 8'h00);
        rdchk("unmapped", 15'h0100, 8'h00);
    endtask
    task automatic t_ratio();
        logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        int n, h;
        foreach (codes[i]) begin
            wr(`ADDR_RATIO, {5'h1f, codes[i]});
            rdchk("ratio", `ADDR_RATIO, {5'h0, codes[i]});
            n = 0;
            h = 0;
            repeat (16) begin
                tick(1);
                n += int'(divTick);
                h += int'(divClk);
            end
            check("ticks", 8'(16 / (codes[i] + 1)), 8'(n));
            check("level", 8'(codes[i] == 3'h0 ? 16 : 8), 8'(h));
        end
        wr(`ADDR_RATIO, 8'h02);
        rdchk("ratio", `ADDR_RATIO, 8'h07);
    endtask
    task automatic t_phase();
        int p0, p1;
        tpos(p0);
        wr(`ADDR_PHASE, 8'hfc);
        rdchk("phase", `ADDR_PHASE, 8'h0c);
        check("invert", 8'h00, {7'h0, clkInvert});
        tpos(p1);
        check("shift", 8'((p0 + 6) % 8), 8'(p1));
        wr(`ADDR_PHASE, 8'h01);
        check("invert", 8'h01, {7'h0, clkInvert});
        tpos(p1);
        check("shift", 8'(p0), 8'(p1));
        wr(`ADDR_PHASE, 8'h00);
    endtask
    task automatic trial(logic [7:0] ctl, int delta, int exp);
        int t0, h;
        wr(`ADDR_ALIGN, 8'h80);
        fire <= 1'b1;
        t0 = cyc;
        tick(1);
        fire <= 1'b0;
        wr(`ADDR_ALIGN, ctl);
        while (cyc < t0 + 320 + delta) tick(1);
        h = hits;
        fire <= 1'b1;
        tick(1);
        fire <= 1'b0;
        tick(8);
        check("realign", 8'(exp), 8'(hits - h));
    endtask
    task automatic t_sysref();
        trial(8'h00, 3, 0);
        trial(8'h80, 3, 1);
        trial(8'h80, 0, 0);
        for (int c = 0; c < 4; c++) begin
            trial(8'h80 | 8'(c << 2), -1, int'(c < 2));
            trial(8'h80 | 8'(c), 1, int'(c < 2));
        end
        wr(`ADDR_ALIGN, 8'hff);
        rdchk("align", `ADDR_ALIGN, 8'h8f);
    endtask
    task automatic stop_test();
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        stop_test();
    end
    initial begin
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        t_reset();
        t_ratio();
        t_phase();
        t_sysref();
        stop_test();
    end
endmodule
